// ===== hw/pocs_out_status.sv
// One output clock status register: enables, sticky latches and real-time bits.
// Assumes event pulses and levels already lie in the master clock domain.
module pocs_out_status
  import pocs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wrEn, // Write strobe for this register
  input wire logic [7:0] wrData,
  input wire logic slowRise, // Slow divider clock went high
  input wire logic slowLevel, // Slow divider clock level
  input wire logic slowReportEn, // Report the inverted slow level
  input wire logic haltedLevel, // Output clock stopped
  input wire logic haltedRise,
  input wire logic haltedFall,
  input wire logic pathReady, // Path configured and clocked
  output logic [7:0] rdData,
  output logic irqReq
);

  logic slowEdgeIrqEn_q, resumeIrqEn_q, haltIrqEn_q;
  logic slowEdgeLatch_q, resumeLatch_q, haltLatch_q;
  logic slowEdgeLatch_d, resumeLatch_d, haltLatch_d;
  logic haltedNow;
  logic clrSlow, clrResume, clrHalt;

  // Write-one-to-clear strobes
  assign clrSlow = wrEn & wrData[BIT_SLOW_EDGE_LATCH];
  assign clrResume = wrEn & wrData[BIT_RESUME_LATCH];
  assign clrHalt = wrEn & wrData[BIT_HALT_LATCH];

  // Set wins over a clear in the same cycle so no event is lost
  assign slowEdgeLatch_d = slowRise | (slowEdgeLatch_q & ~clrSlow);
  assign resumeLatch_d = (haltedFall & pathReady) | (resumeLatch_q & ~clrResume);
  // Halt bits are held at zero until the path has a clock behind it
  assign haltLatch_d = pathReady & ((haltedRise) | (haltLatch_q & ~clrHalt));
  assign haltedNow = pathReady & haltedLevel;

  // Enables and latches
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slowEdgeIrqEn_q <= 1'b0;
      resumeIrqEn_q <= 1'b0;
      haltIrqEn_q <= 1'b0;
      slowEdgeLatch_q <= 1'b0;
      resumeLatch_q <= 1'b0;
      haltLatch_q <= 1'b0;
    end else begin
      if (wrEn) begin
        slowEdgeIrqEn_q <= wrData[BIT_SLOW_EDGE_IRQ_EN];
        resumeIrqEn_q <= wrData[BIT_RESUME_IRQ_EN];
        haltIrqEn_q <= wrData[BIT_HALT_IRQ_EN];
      end
      slowEdgeLatch_q <= slowEdgeLatch_d;
      resumeLatch_q <= resumeLatch_d;
      haltLatch_q <= haltLatch_d;
    end
  end

  // Read image; with slowReportEn set the slow level reads inverted, so zero means the clock is high; without it the bit reads zero
  always_comb begin
    rdData = RST_READ;
    rdData[BIT_SLOW_EDGE_IRQ_EN] = slowEdgeIrqEn_q;
    rdData[BIT_SLOW_EDGE_LATCH] = slowEdgeLatch_q;
    rdData[BIT_SLOW_DIVIDER_LEVEL] = slowReportEn & ~slowLevel;
    rdData[BIT_RESUME_IRQ_EN] = resumeIrqEn_q;
    rdData[BIT_RESUME_LATCH] = resumeLatch_q;
    rdData[BIT_HALT_IRQ_EN] = haltIrqEn_q;
    rdData[BIT_HALT_LATCH] = haltLatch_q;
    rdData[BIT_HALTED_NOW] = haltedNow;
  end

  // Interrupt request gated per latch by its enable
  assign irqReq = (slowEdgeLatch_q & slowEdgeIrqEn_q) | (resumeLatch_q & resumeIrqEn_q)
    | (haltLatch_q & haltIrqEn_q);

endmodule : pocs_out_status

// ===== hw/pocs_pkg.sv
// Constants, field positions and enumerations for the PLL output clock status and control block.
// Assumes an 8-bit register port with 9-bit addresses and a single 200 MHz master clock.
package pocs_pkg;

  // Register offsets
  localparam logic [8:0] OFS_PHASE_ADJ_STATUS = 9'h04D;
  localparam logic [8:0] OFS_OUT1_STATUS = 9'h053;
  localparam logic [8:0] OFS_OUT2_STATUS = 9'h054;
  localparam logic [8:0] OFS_OUT3_STATUS = 9'h055;
  localparam logic [8:0] OFS_DIV_EN_BYPASS = 9'h100;
  localparam logic [8:0] OFS_DIV_RATIOS = 9'h101;
  localparam logic [8:0] OFS_SOURCE_SEL = 9'h102;
  localparam logic [8:0] OFS_PHASE_STEP = 9'h103;

  // Output status register fields
  localparam int BIT_SLOW_EDGE_IRQ_EN = 7;
  localparam int BIT_SLOW_EDGE_LATCH = 6;
  localparam int BIT_SLOW_DIVIDER_LEVEL = 5;
  localparam int BIT_RESUME_IRQ_EN = 4;
  localparam int BIT_RESUME_LATCH = 3;
  localparam int BIT_HALT_IRQ_EN = 2;
  localparam int BIT_HALT_LATCH = 1;
  localparam int BIT_HALTED_NOW = 0;

  // Phase adjust status fields
  localparam int BIT_ADJ_IRQ_EN = 3;
  localparam int BIT_ADJ_DONE = 2;
  localparam int BIT_ADJ_BUSY = 1;
  localparam int BIT_ADJ_ARMED = 0;
  localparam logic ADJ_DONE_RESET = 1'b1;
  localparam logic ADJ_TOP_BIT_VALUE = 1'b1;

  // Divider enable and bypass fields
  localparam int BIT_POST_DIV_TWO_EN = 2;
  localparam int BIT_POST_DIV_TWO_BYPASS = 1;

  // Ratio, source and step field positions
  localparam int POS_POST_DIV_TWO = 4;
  localparam int POS_POST_DIV_ONE = 0;
  localparam int BIT_GPIO_SWITCH_EN = 6;
  localparam int POS_ALT_SOURCE = 3;
  localparam int POS_PRIMARY_SOURCE = 0;
  localparam int BIT_PHASE_DOWN = 7;
  localparam int POS_PHASE_DOWN_SRC = 4;
  localparam int BIT_PHASE_UP = 3;
  localparam int POS_PHASE_UP_SRC = 0;

  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_READ = 8'h00;

  // Ratio decode: codes at or below this value step in halves
  localparam logic [3:0] RATIO_HALF_STEP_MAX = 4'h7;
  localparam logic [4:0] RATIO_BASE_HALVES = 5'h08;

  // Source selection codes
  typedef enum logic [2:0] {
    SRC_XTAL = 3'b000,
    SRC_IN1 = 3'b001,
    SRC_IN2 = 3'b010,
    SRC_IN3 = 3'b011,
    SRC_NCO_IN1_BYP = 3'b100,
    SRC_NCO_NO_BYP_A = 3'b101,
    SRC_NCO_XTAL_BYP = 3'b110,
    SRC_NCO_NO_BYP_B = 3'b111
  } pocs_src_code_t;

  // Clock feeding the PLL reference
  typedef enum logic [2:0] {
    PLL_REF_NONE = 3'b000,
    PLL_REF_XTAL = 3'b001,
    PLL_REF_IN1 = 3'b010,
    PLL_REF_IN2 = 3'b011,
    PLL_REF_IN3 = 3'b100,
    PLL_REF_NCO = 3'b101
  } pocs_pll_ref_t;

  // Clock routed to the bypass mux
  typedef enum logic [1:0] {
    BYP_NONE = 2'b00,
    BYP_XTAL = 2'b01,
    BYP_XTAL_DOUBLED = 2'b10,
    BYP_IN1 = 2'b11
  } pocs_byp_src_t;

  // Phase step source codes
  localparam logic [2:0] STEP_SRC_SOFTWARE = 3'b000;
  localparam logic [2:0] STEP_SRC_GPIO_LAST = 3'b100;

endpackage : pocs_pkg

// ===== hw/pocs_sync3.sv
// Three-stage synchroniser with agreement filter for signals from outside the master clock.
// Assumes the inputs are slow enough that each level lasts several master clock periods.
module pocs_sync3
  import pocs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by the second
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] level_q; // Filtered level
  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] agree;

  // A change counts only once stages two and three agree
  assign agree = ~(stage2_q ^ stage3_q);
  assign level_d = (agree & stage3_q) | (~agree & level_q);

  // Shift chain and filtered level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      level_q <= '0;
    end else begin
      meta_q <= asyncIn;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
    end
  end

  // Edges are taken from the filtered level, so a glitch never steps twice
  assign level = level_q;
  assign rise = level_d & ~level_q;
  assign fall = ~level_d & level_q;

endmodule : pocs_sync3

// ===== hw/pocs_top.sv
// Top of the PLL output clock status and control block: register port, status and PLL config.
// Assumes an 8-bit processor register port on the master clock and status pins from
// the output paths, phase adjust engine and GPIO pads that are asynchronous to it.
module pocs_top
  import pocs_pkg::*;
#(
  parameter int NUM_OUTPUTS = 3,
  parameter int NUM_GPIO = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [8:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic [NUM_OUTPUTS-1:0] slowDividerClk,
  input wire logic [NUM_OUTPUTS-1:0] outputStopped,
  input wire logic [NUM_OUTPUTS-1:0] slowLevelReportEn,
  input wire logic [NUM_OUTPUTS-1:0] outputPathReady,
  input wire logic adjustBusy,
  input wire logic adjustArmed,
  input wire logic adjustDone,
  input wire logic [NUM_GPIO-1:0] gpioIn,
  input wire logic [1:0] switchGpioSel,
  input wire logic xtalDoublerEn,
  input wire logic oscMasterFromInput1,
  input wire logic pllPowerEn,
  output logic postDivTwoRun,
  output logic postDivTwoBypass,
  output logic [4:0] postDivOneHalves,
  output logic [4:0] postDivTwoHalves,
  output pocs_pll_ref_t pllRefSel,
  output pocs_byp_src_t bypassSrcSel,
  output logic phaseUpStep,
  output logic phaseDownStep,
  output logic [NUM_OUTPUTS-1:0] outputIrqReq,
  output logic adjustIrqReq
);

  // Synchronised pin levels and edges
  logic [NUM_OUTPUTS-1:0] slowLevel, slowRise;
  logic [NUM_OUTPUTS-1:0] haltedLevel, haltedRise, haltedFall;
  logic [NUM_OUTPUTS-1:0] pathReady;
  logic [2:0] adjLevel, adjRise;
  logic [NUM_GPIO-1:0] gpioLevel;
  logic [NUM_OUTPUTS-1:0][7:0] outRdData;
  logic [NUM_OUTPUTS-1:0] outWrEn;

  // Software-written configuration registers
  logic [7:0] divEnBypass_q, divRatios_q, sourceSel_q, phaseStep_q;
  logic adjDoneLatch_q, adjDoneLatch_d, adjIrqEn_q;

  // Registered outputs
  logic [7:0] regRdData_q, regRdData_d;
  logic regRdValid_q;
  logic postDivTwoRun_q, postDivTwoBypass_q;
  logic [4:0] postDivOneHalves_q, postDivTwoHalves_q;
  pocs_pll_ref_t pllRefSel_q, pllRefSel_d;
  pocs_byp_src_t bypassSrcSel_q, bypassSrcSel_d;
  logic upLevel_q, downLevel_q, upStep_q, downStep_q;

  // Output path signals cross in from the output clock domains
  pocs_sync3 #(.WIDTH(NUM_OUTPUTS)) u_sync_slow (
    .clock(clock), .rst_b(rst_b), .asyncIn(slowDividerClk),
    .level(slowLevel), .rise(slowRise), .fall()
  );
  pocs_sync3 #(.WIDTH(NUM_OUTPUTS)) u_sync_halt (
    .clock(clock), .rst_b(rst_b), .asyncIn(outputStopped),
    .level(haltedLevel), .rise(haltedRise), .fall(haltedFall)
  );
  pocs_sync3 #(.WIDTH(NUM_OUTPUTS)) u_sync_ready (
    .clock(clock), .rst_b(rst_b), .asyncIn(outputPathReady),
    .level(pathReady), .rise(), .fall()
  );
  // Phase adjust engine status: busy, armed, done
  pocs_sync3 #(.WIDTH(3)) u_sync_adj (
    .clock(clock), .rst_b(rst_b), .asyncIn({adjustDone, adjustBusy, adjustArmed}),
    .level(adjLevel), .rise(adjRise), .fall()
  );
  // GPIO pads feed source switching and phase steps
  pocs_sync3 #(.WIDTH(NUM_GPIO)) u_sync_gpio (
    .clock(clock), .rst_b(rst_b), .asyncIn(gpioIn),
    .level(gpioLevel), .rise(), .fall()
  );

  // Address decode for the three output status registers
  assign outWrEn[0] = regWrEn && (regAddr == OFS_OUT1_STATUS);
  assign outWrEn[1] = regWrEn && (regAddr == OFS_OUT2_STATUS);
  assign outWrEn[2] = regWrEn && (regAddr == OFS_OUT3_STATUS);

  // One identical status register per output
  for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_out
    pocs_out_status u_status (
      .clock(clock),
      .rst_b(rst_b),
      .wrEn(outWrEn[g]),
      .wrData(regWrData),
      .slowRise(slowRise[g]),
      .slowLevel(slowLevel[g]),
      .slowReportEn(slowLevelReportEn[g]),
      .haltedLevel(haltedLevel[g]),
      .haltedRise(haltedRise[g]),
      .haltedFall(haltedFall[g]),
      .pathReady(pathReady[g]),
      .rdData(outRdData[g]),
      .irqReq(outputIrqReq[g])
    );
  end

  // Write strobes for the local registers
  logic wrAdj, wrEnByp, wrRatios, wrSource, wrStep;
  assign wrAdj = regWrEn && (regAddr == OFS_PHASE_ADJ_STATUS);
  assign wrEnByp = regWrEn && (regAddr == OFS_DIV_EN_BYPASS);
  assign wrRatios = regWrEn && (regAddr == OFS_DIV_RATIOS);
  assign wrSource = regWrEn && (regAddr == OFS_SOURCE_SEL);
  assign wrStep = regWrEn && (regAddr == OFS_PHASE_STEP);

  // Done latch: completion event wins over a write-one clear
  assign adjDoneLatch_d = adjRise[2] | (adjDoneLatch_q & ~(wrAdj & regWrData[BIT_ADJ_DONE]));

  // Configuration registers, written whole
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      divEnBypass_q <= RST_CONFIG;
      divRatios_q <= RST_CONFIG;
      sourceSel_q <= RST_CONFIG;
      phaseStep_q <= RST_CONFIG;
      adjIrqEn_q <= 1'b0;
      adjDoneLatch_q <= ADJ_DONE_RESET;
    end else begin
      if (wrEnByp) begin
        divEnBypass_q <= regWrData;
      end
      if (wrRatios) begin
        divRatios_q <= regWrData;
      end
      if (wrSource) begin
        sourceSel_q <= regWrData;
      end
      if (wrStep) begin
        phaseStep_q <= regWrData;
      end
      if (wrAdj) begin
        adjIrqEn_q <= regWrData[BIT_ADJ_IRQ_EN];
      end
      adjDoneLatch_q <= adjDoneLatch_d;
    end
  end

  // Phase adjust status image; busy and armed are live levels from the engine
  logic [7:0] adjImage;
  assign adjImage = {ADJ_TOP_BIT_VALUE, 3'b000, adjIrqEn_q, adjDoneLatch_q,
    adjLevel[1], adjLevel[0]};
  assign adjustIrqReq = adjDoneLatch_q & adjIrqEn_q;

  // Read mux; unmapped addresses read zero
  always_comb begin
    if (regAddr == OFS_PHASE_ADJ_STATUS) begin
      regRdData_d = adjImage;
    end else if (regAddr == OFS_OUT1_STATUS) begin
      regRdData_d = outRdData[0];
    end else if (regAddr == OFS_OUT2_STATUS) begin
      regRdData_d = outRdData[1];
    end else if (regAddr == OFS_OUT3_STATUS) begin
      regRdData_d = outRdData[2];
    end else if (regAddr == OFS_DIV_EN_BYPASS) begin
      regRdData_d = divEnBypass_q;
    end else if (regAddr == OFS_DIV_RATIOS) begin
      regRdData_d = divRatios_q;
    end else if (regAddr == OFS_SOURCE_SEL) begin
      regRdData_d = sourceSel_q;
    end else if (regAddr == OFS_PHASE_STEP) begin
      regRdData_d = phaseStep_q;
    end else begin
      regRdData_d = RST_READ;
    end
  end

  // Ratio decode in half steps: low codes add half the code to four
  function automatic logic [4:0] ratioHalves(input logic [3:0] code);
    logic [4:0] halves;
    if (code <= RATIO_HALF_STEP_MAX) begin
      halves = RATIO_BASE_HALVES + {1'b0, code};
    end else begin
      halves = {code, 1'b0};
    end
    return halves;
  endfunction : ratioHalves

  // Effective source code: GPIO high picks the alternate field when switching is on
  logic switchGpio, useAlt;
  logic [2:0] altCode;
  pocs_src_code_t srcCode;
  assign switchGpio = gpioLevel[switchGpioSel];
  assign useAlt = sourceSel_q[BIT_GPIO_SWITCH_EN] & switchGpio;
  assign altCode = sourceSel_q[POS_ALT_SOURCE +: 3];
  assign srcCode = pocs_src_code_t'(useAlt ? altCode : sourceSel_q[POS_PRIMARY_SOURCE +: 3]);

  // Source decode; alternate codes above three are unused and select nothing
  always_comb begin
    pllRefSel_d = PLL_REF_NONE;
    bypassSrcSel_d = BYP_NONE;
    case (srcCode)
      SRC_XTAL: begin
        pllRefSel_d = PLL_REF_XTAL;
        bypassSrcSel_d = xtalDoublerEn ? BYP_XTAL_DOUBLED : BYP_XTAL;
      end
      SRC_IN1: begin
        pllRefSel_d = PLL_REF_IN1;
        bypassSrcSel_d = BYP_IN1;
      end
      SRC_IN2: begin
        pllRefSel_d = PLL_REF_IN2;
      end
      SRC_IN3: begin
        pllRefSel_d = PLL_REF_IN3;
      end
      SRC_NCO_IN1_BYP: begin
        if (!useAlt && oscMasterFromInput1) begin
          pllRefSel_d = PLL_REF_NCO;
          bypassSrcSel_d = BYP_IN1;
        end
      end
      SRC_NCO_NO_BYP_A: begin
        if (!useAlt && oscMasterFromInput1) begin
          pllRefSel_d = PLL_REF_NCO;
        end
      end
      SRC_NCO_XTAL_BYP: begin
        if (!useAlt) begin
          pllRefSel_d = PLL_REF_NCO;
          bypassSrcSel_d = xtalDoublerEn ? BYP_XTAL_DOUBLED : BYP_XTAL;
        end
      end
      SRC_NCO_NO_BYP_B: begin
        if (!useAlt) begin
          pllRefSel_d = PLL_REF_NCO;
        end
      end
      default: begin
        pllRefSel_d = PLL_REF_NONE;
      end
    endcase
  end

  // Phase step signal selection: software bit or one of the GPIOs
  function automatic logic stepSource(input logic [2:0] sel, input logic swBit,
    input logic [NUM_GPIO-1:0] gpio);
    logic lvl;
    lvl = 1'b0;
    if (sel == STEP_SRC_SOFTWARE) begin
      lvl = swBit;
    end else if (sel <= STEP_SRC_GPIO_LAST) begin
      lvl = gpio[2'(sel - 3'h1)];
    end
    return lvl;
  endfunction : stepSource

  logic upLevel, downLevel;
  assign downLevel = stepSource(phaseStep_q[POS_PHASE_DOWN_SRC +: 3], phaseStep_q[BIT_PHASE_DOWN],
    gpioLevel);
  assign upLevel = stepSource(phaseStep_q[POS_PHASE_UP_SRC +: 3], phaseStep_q[BIT_PHASE_UP],
    gpioLevel);

  // Derived controls and step pulses; any change of level is one step
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_q <= RST_READ;
      regRdValid_q <= 1'b0;
      postDivTwoRun_q <= 1'b0;
      postDivTwoBypass_q <= 1'b0;
      postDivOneHalves_q <= RATIO_BASE_HALVES;
      postDivTwoHalves_q <= RATIO_BASE_HALVES;
      pllRefSel_q <= PLL_REF_NONE;
      bypassSrcSel_q <= BYP_NONE;
      upLevel_q <= 1'b0;
      downLevel_q <= 1'b0;
      upStep_q <= 1'b0;
      downStep_q <= 1'b0;
    end else begin
      regRdData_q <= regRdEn ? regRdData_d : regRdData_q;
      regRdValid_q <= regRdEn;
      postDivTwoRun_q <= pllPowerEn & divEnBypass_q[BIT_POST_DIV_TWO_EN]
        & ~divEnBypass_q[BIT_POST_DIV_TWO_BYPASS];
      postDivTwoBypass_q <= divEnBypass_q[BIT_POST_DIV_TWO_BYPASS];
      postDivOneHalves_q <= ratioHalves(divRatios_q[POS_POST_DIV_ONE +: 4]);
      postDivTwoHalves_q <= ratioHalves(divRatios_q[POS_POST_DIV_TWO +: 4]);
      pllRefSel_q <= pllRefSel_d;
      bypassSrcSel_q <= bypassSrcSel_d;
      upLevel_q <= upLevel;
      downLevel_q <= downLevel;
      // Changing the source select can itself produce a step if levels differ
      downStep_q <= downLevel ^ downLevel_q;
      upStep_q <= upLevel ^ upLevel_q;
    end
  end

  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;
  assign postDivTwoRun = postDivTwoRun_q;
  assign postDivTwoBypass = postDivTwoBypass_q;
  assign postDivOneHalves = postDivOneHalves_q;
  assign postDivTwoHalves = postDivTwoHalves_q;
  assign pllRefSel = pllRefSel_q;
  assign bypassSrcSel = bypassSrcSel_q;
  assign phaseUpStep = upStep_q;
  assign phaseDownStep = downStep_q;

endmodule : pocs_top

// ===== sim/pocs_top_checker.sv
// Assertions on the ports of the PLL output clock status and control top.
// Assumes a bind onto pocs_top; one clock domain with an active-low async reset.
module pocs_top_checker
  import pocs_pkg::*;
#(
  parameter int NUM_OUTPUTS = 3
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [8:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic pllPowerEn,
  input wire logic postDivTwoRun,
  input wire logic postDivTwoBypass,
  input wire logic [4:0] postDivOneHalves,
  input wire logic [4:0] postDivTwoHalves,
  input wire logic [NUM_OUTPUTS-1:0] outputIrqReq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Read answer one cycle after its strobe, never unasked
  read_valid_a: assert property (regRdEn |=> regRdValid) else $error("read valid missing");
  read_idle_a: assert property (!regRdEn |=> !regRdValid) else $error("read valid without strobe");
  // Holes in the map read as zero
  read_hole_a: assert property (regRdEn && regAddr == 9'h0FF |=> regRdData == 8'h00) else $error("hole read");
  // Divider two may only run with power on and no bypass
  div_two_run_a: assert property (postDivTwoRun |-> $past(pllPowerEn) && !postDivTwoBypass)
    else $error("divider two runs illegally");
  bypass_follow_a: assert property (regWrEn && regAddr == OFS_DIV_EN_BYPASS |=> ##1
    postDivTwoBypass == $past(regWrData[1], 2)) else $error("bypass not applied");
  // Half-step codes below eight, whole codes from eight
  ratio_one_a: assert property (regWrEn && regAddr == OFS_DIV_RATIOS |=> ##1 postDivOneHalves ==
    ($past(regWrData[3], 2) ? {$past(regWrData[3:0], 2), 1'b0} : 5'h08 + $past(regWrData[2:0], 2)))
    else $error("ratio one wrong");
  ratio_two_a: assert property (regWrEn && regAddr == OFS_DIV_RATIOS |=> ##1 postDivTwoHalves ==
    ($past(regWrData[7], 2) ? {$past(regWrData[7:4], 2), 1'b0} : 5'h08 + $past(regWrData[6:4], 2)))
    else $error("ratio two wrong");
  // With every enable cleared the output request must drop
  irq_masked_a: assert property (regWrEn && regAddr == OFS_OUT1_STATUS && (regWrData & 8'h94) == 8'h00 |=>
    !outputIrqReq[0]) else $error("request while masked");
endmodule : pocs_top_checker

// ===== sim/pocs_top_test.sv
// Self-checking bench for the PLL output clock status and control top.
// Assumes one-cycle register strobes and three-stage pin synchronisers.
module pocs_top_test
  import pocs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, regWrEn, regRdEn, regRdValid, adjustBusy, adjustArmed, adjustDone;
  logic xtalDoublerEn, oscMasterFromInput1, pllPowerEn, postDivTwoRun, postDivTwoBypass;
  logic phaseUpStep, phaseDownStep, adjustIrqReq;
  logic [8:0] regAddr;
  logic [7:0] regWrData, regRdData, v;
  logic [2:0] slowDividerClk, outputStopped, slowLevelReportEn, outputPathReady, outputIrqReq;
  logic [3:0] gpioIn;
  logic [1:0] switchGpioSel;
  logic [4:0] postDivOneHalves, postDivTwoHalves;
  pocs_pll_ref_t pllRefSel;
  pocs_byp_src_t bypassSrcSel;
  logic [31:0] lfsr = 32'h00010518; // Seed 66840
  int nMismatch, samplesChecked, cycles, nUp, nDown, d0, u0;
  pocs_top pocs_top_inst (.clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .slowDividerClk(slowDividerClk), .outputStopped(outputStopped), .slowLevelReportEn(slowLevelReportEn),
    .outputPathReady(outputPathReady), .adjustBusy(adjustBusy), .adjustArmed(adjustArmed),
    .adjustDone(adjustDone), .gpioIn(gpioIn), .switchGpioSel(switchGpioSel), .xtalDoublerEn(xtalDoublerEn),
    .oscMasterFromInput1(oscMasterFromInput1), .pllPowerEn(pllPowerEn), .postDivTwoRun(postDivTwoRun),
    .postDivTwoBypass(postDivTwoBypass), .postDivOneHalves(postDivOneHalves),
    .postDivTwoHalves(postDivTwoHalves), .pllRefSel(pllRefSel), .bypassSrcSel(bypassSrcSel),
    .phaseUpStep(phaseUpStep), .phaseDownStep(phaseDownStep), .outputIrqReq(outputIrqReq),
    .adjustIrqReq(adjustIrqReq));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Step pulses counted at every rising edge; cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cycles++;
    nUp += (phaseUpStep === 1'b1);
    nDown += (phaseDownStep === 1'b1);
    if (cycles == 20000) begin
      nMismatch++;
      finishTest();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask : wr
  // Strobe one cycle, check the answer once settled
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clock);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRdEn <= 1'b0;
    @(negedge clock);
    chk("valid", {7'h00, regRdValid}, 8'h01);
    chk("read", regRdData, exp);
  endtask : rd
  task automatic wait_sync();
    repeat (6) @(posedge clock);
  endtask : wait_sync
  // Model of the ratio, reference and bypass decodes
  function automatic int halves(input int c);
    return (c <= 7) ? 8 + c : 2 * c;
  endfunction : halves
  function automatic int refOf(input int c, input int alt);
    if (c < 4) return c + 1;
    return (alt == 1 || (c < 6 && !oscMasterFromInput1)) ? PLL_REF_NONE : PLL_REF_NCO;
  endfunction : refOf
  function automatic int bypOf(input int c);
    if (c == 0 || c == 6) return xtalDoublerEn ? BYP_XTAL_DOUBLED : BYP_XTAL;
    return (c == 1 || (c == 4 && oscMasterFromInput1)) ? BYP_IN1 : BYP_NONE;
  endfunction : bypOf
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  task automatic finishTest();
    $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finishTest
  initial begin
    {rst_b, regWrEn, regRdEn, adjustBusy, adjustArmed, adjustDone, xtalDoublerEn} = '0;
    {oscMasterFromInput1, pllPowerEn, regAddr, regWrData, gpioIn, switchGpioSel} = '0;
    {slowDividerClk, slowLevelReportEn, outputPathReady} = '0;
    outputStopped = 3'b010; // Stopped but path not ready: must read zero
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rd(OFS_DIV_EN_BYPASS + 9'(i), RST_CONFIG);
    rd(OFS_PHASE_ADJ_STATUS, 8'h84);
    rd(OFS_OUT2_STATUS, 8'h00);
    rd(9'h0FF, 8'h00);
    $display("reset test done");
    for (int c = 0; c < 16; c++) begin
      wr(OFS_DIV_RATIOS, {4'(c), 4'(15 - c)});
      repeat (2) @(posedge clock);
      chk("ratio two", 8'(postDivTwoHalves), 8'(halves(c)));
      chk("ratio one", 8'(postDivOneHalves), 8'(halves(15 - c)));
    end
    for (int i = 0; i < 8; i++) begin
      lfsr = rnd(lfsr);
      v = {lfsr[7:3], 2'(i), lfsr[0]};
      @(posedge clock);
      pllPowerEn <= i[2];
      wr(OFS_DIV_EN_BYPASS, v);
      repeat (2) @(posedge clock);
      chk("run", 8'(postDivTwoRun), 8'(i == 6));
      chk("bypass", 8'(postDivTwoBypass), 8'(i[0]));
      rd(OFS_DIV_EN_BYPASS, v);
    end
    $display("divider test done");
    wr(OFS_DIV_EN_BYPASS, 8'h00);
    for (int i = 0; i < 16; i++) begin
      lfsr = rnd(lfsr);
      @(posedge clock);
      xtalDoublerEn <= lfsr[4];
      oscMasterFromInput1 <= i[3];
      wr(OFS_SOURCE_SEL, {2'b00, lfsr[2:0], 3'(i)});
      repeat (3) @(posedge clock);
      chk("reference", 8'(pllRefSel), 8'(refOf(i % 8, 0)));
      chk("bypass source", 8'(bypassSrcSel), 8'(bypOf(i % 8)));
    end
    switchGpioSel <= 2'h2;
    for (int a = 0; a < 8; a++) begin
      wr(OFS_SOURCE_SEL, {2'b01, 3'(a), 3'h0});
      gpioIn[2] <= 1'b1;
      wait_sync();
      chk("alternate", 8'(pllRefSel), 8'(refOf(a, 1)));
      gpioIn[2] <= 1'b0;
      wait_sync();
      chk("primary", 8'(pllRefSel), 8'(PLL_REF_XTAL));
    end
    $display("source test done");
    d0 = nDown;
    u0 = nUp;
    for (int i = 0; i < 8; i++) wr(OFS_PHASE_STEP, (i % 2) ? 8'h00 : (i < 4 ? 8'h80 : 8'h08)); // Step bits toggle
    for (int s = 1; s < 5; s++) begin
      wr(OFS_PHASE_STEP, {1'b0, 3'(s), 1'b0, 3'(s)});
      for (int k = 0; k < 2; k++) begin
        gpioIn[s - 1] <= !k;
        wait_sync();
      end
    end
    wait_sync();
    chk("down steps", 8'(nDown - d0), 8'h0C);
    chk("up steps", 8'(nUp - u0), 8'h0C);
    $display("step test done");
    outputPathReady <= 3'b111;
    outputStopped <= 3'b000;
    slowDividerClk[0] <= 1'b1;
    slowLevelReportEn[0] <= 1'b1;
    wait_sync();
    rd(OFS_OUT1_STATUS, 8'h40);
    slowDividerClk[0] <= 1'b0;
    wait_sync();
    rd(OFS_OUT1_STATUS, 8'h60);
    wr(OFS_OUT1_STATUS, 8'hC0);
    rd(OFS_OUT1_STATUS, 8'hA0);
    chk("irq", 8'(outputIrqReq), 8'h00);
    slowDividerClk[0] <= 1'b1;
    wait_sync();
    chk("irq", 8'(outputIrqReq), 8'h01);
    wr(OFS_OUT1_STATUS, 8'h54);
    outputStopped[0] <= 1'b1;
    wait_sync();
    rd(OFS_OUT1_STATUS, 8'h17);
    outputStopped[0] <= 1'b0;
    wait_sync();
    rd(OFS_OUT1_STATUS, 8'h1E);
    wr(OFS_OUT1_STATUS, 8'h0A);
    rd(OFS_OUT1_STATUS, 8'h00);
    chk("irq", 8'(outputIrqReq), 8'h00);
    $display("status test done");
    {adjustBusy, adjustArmed} <= 2'b11;
    wait_sync();
    rd(OFS_PHASE_ADJ_STATUS, 8'h87);
    adjustArmed <= 1'b0;
    wait_sync();
    rd(OFS_PHASE_ADJ_STATUS, 8'h86);
    wr(OFS_PHASE_ADJ_STATUS, 8'h08);
    @(negedge clock);
    chk("adj irq", 8'(adjustIrqReq), 8'h01);
    $display("adjust test done");
    finishTest();
  end
endmodule : pocs_top_test
bind pocs_top pocs_top_checker #(.NUM_OUTPUTS(NUM_OUTPUTS)) pocs_top_checker_inst (.clock(clock),
  .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
  .regRdData(regRdData), .regRdValid(regRdValid), .pllPowerEn(pllPowerEn), .postDivTwoRun(postDivTwoRun),
  .postDivTwoBypass(postDivTwoBypass), .postDivOneHalves(postDivOneHalves),
  .postDivTwoHalves(postDivTwoHalves), .outputIrqReq(outputIrqReq));
